// ==== fae_output_encoder.sv ====
`timescale 1ns/1ps
// Functional notes
// - compare input to 255 thresholds, thermometer vector
// - thresholds below input asserted, above deasserted
// - every conversion yields one 8-bit word
// - coding follows selected format controls
// - four codings: binary/offset, true/inverted
// - output register holds word between updates
// - one convert clock drives all stages
// - in-range input spans codes 0 to 255
// - out-of-range input saturates, never wraps
// - latch, encode, load: sample N after edge N+3
// - active-low static controls: top bit, low seven
// - both controls high: top reference gives zero
module fae_output_encoder (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [fae_pkg::THERM_W-1:0] comparator_in,
    input wire logic top_bit_invert_n,
    input wire logic low_bits_invert_n,
    output logic [fae_pkg::WORD_W-1:0] sample_word_ff,
    output logic sample_valid_ff
);
    // comparator outputs are asynchronous to clk: two-stage latch
    logic [fae_pkg::THERM_W-1:0] therm_meta_ff;
    logic [fae_pkg::THERM_W-1:0] therm_ff;
    logic [1:0] top_sync_ff;
    logic [1:0] low_sync_ff;
    logic [fae_pkg::WORD_W-1:0] count;
    logic [fae_pkg::WORD_W-1:0] nxt_sample_word;
    logic [1:0] valid_pipe_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            therm_meta_ff <= fae_pkg::THERM_RST;
            therm_ff <= fae_pkg::THERM_RST;
        end else if (ce) begin
            therm_meta_ff <= comparator_in;
            therm_ff <= therm_meta_ff;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            top_sync_ff <= 2'h3;
            low_sync_ff <= 2'h3;
        end else if (ce) begin
            top_sync_ff <= {top_sync_ff[0], top_bit_invert_n};
            low_sync_ff <= {low_sync_ff[0], low_bits_invert_n};
        end
    end

    fae_therm_count u_count (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .therm(therm_ff),
        .count_ff(count)
    );

    // count rises with voltage; true binary counts down, count of 255 is 0
    always_comb begin
        nxt_sample_word = fae_pkg::FULL_CODE - count;
        if (!top_sync_ff[1]) begin
            nxt_sample_word = nxt_sample_word ^ fae_pkg::TOP_MASK;
        end
        if (!low_sync_ff[1]) begin
            nxt_sample_word = nxt_sample_word ^ fae_pkg::LOW_MASK;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sample_word_ff <= fae_pkg::WORD_RST;
        end else if (ce) begin
            sample_word_ff <= nxt_sample_word;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            valid_pipe_ff <= 2'h0;
            sample_valid_ff <= 1'b0;
        end else if (ce) begin
            valid_pipe_ff <= {valid_pipe_ff[0], 1'b1};
            sample_valid_ff <= valid_pipe_ff[1];
        end
    end

    logic [fae_pkg::WORD_W-1:0] true_ref;
    assign true_ref = fae_pkg::FULL_CODE - count;

    property p_hold;
        @(posedge clk) disable iff (rst) !ce |=> $stable(sample_word_ff);
    endproperty
    word_hold_a: assert property (p_hold) else $error("word changed while frozen");

    fmt_true_a: assert property (@(posedge clk) disable iff (rst)
        ce && top_sync_ff[1] && low_sync_ff[1] |=> sample_word_ff == $past(true_ref))
        else $error("true binary code wrong");
    fmt_both_a: assert property (@(posedge clk) disable iff (rst)
        ce && !top_sync_ff[1] && !low_sync_ff[1] |=> sample_word_ff == ~$past(true_ref))
        else $error("inverted binary code wrong");
    fmt_top_a: assert property (@(posedge clk) disable iff (rst)
        ce && !top_sync_ff[1] && low_sync_ff[1]
        |=> sample_word_ff == ($past(true_ref) ^ fae_pkg::TOP_MASK))
        else $error("top bit invert wrong");
    fmt_low_a: assert property (@(posedge clk) disable iff (rst)
        ce && top_sync_ff[1] && !low_sync_ff[1]
        |=> sample_word_ff == ($past(true_ref) ^ fae_pkg::LOW_MASK))
        else $error("low bits invert wrong");
    sat_full_a: assert property (@(posedge clk) disable iff (rst)
        ce && (&therm_ff) && top_sync_ff[1] && low_sync_ff[1] && $stable(top_sync_ff)
        && $stable(low_sync_ff) ##1 ce && top_sync_ff[1] && low_sync_ff[1]
        |=> sample_word_ff == 8'h00)
        else $error("top saturation wrong");
    sat_zero_a: assert property (@(posedge clk) disable iff (rst)
        ce && therm_ff == fae_pkg::THERM_RST && top_sync_ff[1] && low_sync_ff[1]
        && $stable(top_sync_ff) && $stable(low_sync_ff) ##1 ce && top_sync_ff[1] && low_sync_ff[1]
        |=> sample_word_ff == 8'hFF)
        else $error("bottom saturation wrong");
    lat_pipe_a: assert property (@(posedge clk) disable iff (rst)
        ce |=> count == $past(count_ones(therm_ff)))
        else $error("count latency wrong");

    // reference helpers for the checks above and below; not part of the datapath
    function automatic logic [fae_pkg::WORD_W-1:0] count_ones(
        input logic [fae_pkg::THERM_W-1:0] v
    );
        logic [fae_pkg::WORD_W-1:0] acc;
        acc = 8'h00;
        for (int i = 0; i < fae_pkg::THERM_W; i++) begin
            acc = acc + {7'h00, v[i]};
        end
        return acc;
    endfunction

    // applies the two active-low inversions to a true binary word
    function automatic logic [fae_pkg::WORD_W-1:0] apply_format(
        input logic [fae_pkg::WORD_W-1:0] word,
        input logic top_n,
        input logic low_n
    );
        logic [fae_pkg::WORD_W-1:0] res;
        res = word;
        if (!top_n) begin
            res = res ^ fae_pkg::TOP_MASK;
        end
        if (!low_n) begin
            res = res ^ fae_pkg::LOW_MASK;
        end
        return res;
    endfunction

    // counts enabled edges since reset, saturating once the pipeline is full
    logic [1:0] fill_cnt_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fill_cnt_ff <= 2'h0;
        end else if (ce && fill_cnt_ff != 2'h3) begin
            fill_cnt_ff <= fill_cnt_ff + 2'h1;
        end
    end

    // first latch stage must follow the comparator pins on every enabled edge
    meta_take_a: assert property (@(posedge clk) disable iff (rst)
        ce |=> therm_meta_ff == $past(comparator_in))
        else $error("comparator latch wrong");

    therm_pipe_a: assert property (@(posedge clk) disable iff (rst)
        ce |=> therm_ff == $past(therm_meta_ff))
        else $error("thermometer stage wrong");

    sync_pipe_a: assert property (@(posedge clk) disable iff (rst)
        ce |=> top_sync_ff[1] == $past(top_sync_ff[0])
        && low_sync_ff[1] == $past(low_sync_ff[0]))
        else $error("format sync wrong");

    // a low enable must freeze every stage, not only the output word
    freeze_all_a: assert property (@(posedge clk) disable iff (rst)
        !ce |=> $stable(therm_ff) && $stable(count) && $stable(top_sync_ff)
        && $stable(low_sync_ff) && $stable(sample_valid_ff))
        else $error("stage moved while frozen");

    fmt_any_a: assert property (@(posedge clk) disable iff (rst)
        ce |=> sample_word_ff
        == apply_format($past(true_ref), $past(top_sync_ff[1]), $past(low_sync_ff[1])))
        else $error("format coding wrong");

    // valid rises after three enabled edges and never drops until reset
    valid_fill_a: assert property (@(posedge clk) disable iff (rst)
        sample_valid_ff == (fill_cnt_ff == 2'h3))
        else $error("valid timing wrong");

    valid_stay_a: assert property (@(posedge clk) disable iff (rst)
        sample_valid_ff |=> sample_valid_ff)
        else $error("valid dropped");

    // mid scale: offset codes cross zero where binary reads 80
    mid_offset_a: assert property (@(posedge clk) disable iff (rst)
        ce && count == 8'h7F && !top_sync_ff[1] && low_sync_ff[1]
        |=> sample_word_ff == 8'h00)
        else $error("offset true mid code wrong");

    mid_offinv_a: assert property (@(posedge clk) disable iff (rst)
        ce && count == 8'h7F && top_sync_ff[1] && !low_sync_ff[1]
        |=> sample_word_ff == 8'hFF)
        else $error("offset inverted mid code wrong");

    // the word is a function of the count alone, so bubbles cost one step
    count_word_a: assert property (@(posedge clk) disable iff (rst)
        ce && top_sync_ff[1] && low_sync_ff[1]
        |=> sample_word_ff == fae_pkg::FULL_CODE - $past(count))
        else $error("word not from count");
endmodule

// ==== fae_pkg.sv ====
package fae_pkg;
    localparam int THERM_W = 255;
    localparam int WORD_W = 8;
    localparam int MSB_POS = 7;
    localparam logic [7:0] WORD_RST = 8'h00;
    localparam logic [7:0] LOW_MASK = 8'h7F;
    localparam logic [7:0] TOP_MASK = 8'h80;
    localparam logic [7:0] FULL_CODE = 8'hFF;
    localparam logic [THERM_W-1:0] THERM_RST = '0;
endpackage

// ==== fae_therm_count.sv ====
`timescale 1ns/1ps
// population count of the latched comparator vector, result registered
module fae_therm_count (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [fae_pkg::THERM_W-1:0] therm,
    output logic [fae_pkg::WORD_W-1:0] count_ff
);
    function automatic logic [7:0] pop_count(input logic [fae_pkg::THERM_W-1:0] v);
        logic [7:0] acc;
        acc = 8'h00;
        for (int i = 0; i < fae_pkg::THERM_W; i++) begin
            acc = acc + {7'h00, v[i]};
        end
        return acc;
    endfunction

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_ff <= fae_pkg::WORD_RST;
        end else if (ce) begin
            count_ff <= pop_count(therm);
        end
    end
endmodule

// ==== fae_capture_model.sv ====
`timescale 1ns/1ps
// downstream logic: takes each word once the pipeline reports valid
module fae_capture_model (
    input wire logic clk,
    input wire logic valid,
    input wire logic [fae_pkg::WORD_W-1:0] word,
    output logic [fae_pkg::WORD_W-1:0] held_ff
);
    always_ff @(posedge clk) begin
        if (valid) begin
            held_ff <= word;
        end
    end
endmodule

// ==== test_flash_adc_output_encoder.sv ====
`timescale 1ns/1ps
module test_flash_adc_output_encoder;
    logic clk = 0, rst = 1, ce = 1, top_n = 1, low_n = 1, valid;
    logic [254:0] th = '0;
    logic [7:0] word, held;
    int failures = 0, total_checks = 0, cyc = 0;
    fae_output_encoder dut (.clk(clk), .rst(rst), .ce(ce), .comparator_in(th),
        .top_bit_invert_n(top_n), .low_bits_invert_n(low_n), .sample_word_ff(word),
        .sample_valid_ff(valid));
    fae_capture_model cap (.clk(clk), .valid(valid), .word(word), .held_ff(held));
    initial forever #4 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic cmp(string name, logic [7:0] exp, logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    function automatic logic [254:0] therm(int n);
        logic [254:0] v = '1;
        return v >> (255 - n);
    endfunction
    // expected code: counts down with level, then the two static inversions
    function automatic logic [7:0] code(int n, logic t, logic l);
        return 8'(255 - n) ^ {~t, {7{~l}}};
    endfunction
    task automatic convert_clock(int n, logic t, logic l);
        @(negedge clk);
        th = therm(n);
        top_n = t;
        low_n = l;
        repeat (6) @(negedge clk);
        cmp("word", code(n, t, l), word);
        cmp("held", code(n, t, l), held);
    endtask
    task automatic t_codes();
        int ns[6] = '{0, 1, 127, 128, 254, 255};
        for (int f = 0; f < 4; f++) begin
            foreach (ns[i]) convert_clock(ns[i], f[1], f[0]);
        end
    endtask
    task automatic t_bubble();
        convert_clock(10, 1, 1);
        th = therm(100);
        th[150] = 1'b1;
        th[50] = 1'b0;
        repeat (6) @(negedge clk);
        cmp("bubble", 8'h9B, word);
    endtask
    task automatic t_latency();
        convert_clock(10, 1, 1);
        th = therm(200);
        repeat (3) @(negedge clk);
        cmp("early", code(10, 1, 1), word);
        @(negedge clk);
        cmp("due", code(200, 1, 1), word);
    endtask
    task automatic t_hold();
        convert_clock(40, 1, 1);
        ce = 0;
        th = therm(90);
        repeat (6) @(negedge clk);
        cmp("frozen", code(40, 1, 1), word);
        ce = 1;
        repeat (6) @(negedge clk);
        cmp("resumed", code(90, 1, 1), word);
    endtask
    initial begin
        repeat (3) @(negedge clk);
        cmp("reset_word", 8'h00, word);
        rst = 0;
        t_codes();
        cmp("valid", 8'h01, {7'h00, valid});
        t_bubble();
        t_latency();
        t_hold();
        final_report();
    end
endmodule
